// ===== core/dip_image_packer.sv
// Input process image packer: APB registers, scan sequencer and image store.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// =============================================================================

module dip_image_packer
   import dip_pkg::*;
(
   input  wire logic                         clk_sys_in,     // 200 MHz system clock.
   input  wire logic                         rst_in,         // Synchronous reset, high.
   input  wire logic                         ce_in,          // Low freezes all state.
   input  wire logic                         psel_in,        // APB select.
   input  wire logic                         penable_in,     // APB access phase.
   input  wire logic                         pwrite_in,      // APB write.
   input  wire logic [7:0]                   paddr_in,       // APB byte address.
   input  wire logic [31:0]                  pwdata_in,      // APB write data.
   output logic                              pready_out,     // APB ready.
   output logic [31:0]                       prdata_out,     // APB read data.
   output logic                              pslverr_out,    // APB error, unmapped.
   input  wire logic [NUM_SLOTS-1:0][7:0]    chan_state_in,  // Channel state pins.
   input  wire logic [NUM_SLOTS-1:0][7:0]    chan_fault_in,  // Channel fault pins.
   input  wire logic [ANA_MAX-1:0][15:0]     analog_word_in, // Analog values, same clock.
   output logic                              irq_out         // Level interrupt.
);

   // ==========================================================================
   // Declarations.
   logic [PIN_W-1:0]             pin_s;
   logic [NUM_SLOTS-1:0][7:0]    st_s;
   logic [NUM_SLOTS-1:0][7:0]    ft_s;
   dip_field_s [NUM_SLOTS-1:0]   fld;
   logic [NUM_SLOTS*CH_MAX-1:0]  fu;
   logic [NUM_SLOTS-1:0]         flt_slot;
   logic [3:0]                   cur_w;

   dip_state_e                   state_q, state_d;
   logic [3:0]                   idx_q, idx_d;
   logic [2:0]                   slot_q, slot_d;
   logic [7:0]                   ptr_q, ptr_d;
   logic [IMG_BITS-1:0]          work_q, work_d;
   logic [IMG_BITS-1:0]          image_q, image_d;
   logic                         done_ev;

   logic                         ctrl_en_q, ctrl_en_d;
   logic [STAT_W-1:0]            stat_q, stat_d;
   logic [STAT_W-1:0]            mask_q, mask_d;
   logic [3:0]                   ana_q, ana_d;
   logic [NUM_SLOTS-1:0][2:0]    kind_q, kind_d;
   logic [NUM_SLOTS*CH_MAX-1:0]  fprev_q, fprev_d;
   logic                         pready_q, pready_d;
   logic [31:0]                  prdata_q, prdata_d;
   logic                         pslverr_q, pslverr_d;
   logic                         irq_q, irq_d;
   logic                         acc, wr, hit, flt_rise;
   logic [31:0]                  rdata;
   logic [STAT_W-1:0]            stat_set, stat_clr;

   // ==========================================================================
   // Pins cross into the clock domain before anything looks at them.
   dip_sync #(.W(PIN_W)) u_sync (
      .clk_in (clk_sys_in),
      .ce_in  (ce_in),
      .rst_in (rst_in),
      .d_in   ({chan_fault_in, chan_state_in}),
      .q_out  (pin_s)
   );

   assign st_s = pin_s[NUM_SLOTS*CH_MAX-1:0];
   assign ft_s = pin_s[PIN_W-1:NUM_SLOTS*CH_MAX];

   // ==========================================================================
   // One field formatter per slot; the fault summary is one bit per slot.
   for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      dip_field_packer u_pack (
         .kind_in        (kind_q[s]),
         .state_in       (st_s[s]),
         .fault_in       (ft_s[s]),
         .field_out      (fld[s]),
         .fault_used_out (fu[s*CH_MAX +: CH_MAX])
      );
      assign flt_slot[s] = |fu[s*CH_MAX +: CH_MAX];
   end

   assign cur_w = fld[slot_q].width;

   // ==========================================================================
   // Scan sequencer. A pass clears the work copy, copies the analog words,
   // packs one slot per cycle and then publishes the whole image in one edge,
   // so software never reads a half-built image. Kind codes are read live, so
   // changing them mid-pass gives one mixed pass; disable the scan first.
   always_comb begin
      state_d = state_q;
      idx_d   = idx_q;
      slot_d  = slot_q;
      ptr_d   = ptr_q;
      work_d  = work_q;
      image_d = image_q;
      done_ev = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (ctrl_en_q) begin
               work_d  = '0;
               idx_d   = 4'h0;
               state_d = ST_ANALOG;
            end
         end
         ST_ANALOG: begin
            if (idx_q < ana_q) begin
               // Low byte lands in bits 7:0, the lower byte address.
               work_d[{idx_q[2:0], 4'h0} +: WORD_W] = analog_word_in[idx_q[2:0]];
               idx_d = idx_q + 4'h1;
            end else begin
               ptr_d   = {ana_q, 4'h0};
               slot_d  = 3'h0;
               state_d = ST_DIGITAL;
            end
         end
         ST_DIGITAL: begin
            // Fields sit back to back, so bits from several modules share bytes.
            for (int i = 0; i < CH_MAX; i++) begin
               if (4'(i) < cur_w) begin
                  work_d[8'(ptr_q + 8'(i))] = fld[slot_q].bits[i];
               end
            end
            ptr_d  = ptr_q + {4'h0, cur_w};
            slot_d = slot_q + 3'h1;
            if (slot_q == 3'(NUM_SLOTS - 1)) begin
               state_d = ST_PUBLISH;
            end
         end
         ST_PUBLISH: begin
            image_d = work_q;
            done_ev = 1'b1;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         state_q <= ST_IDLE;
         idx_q   <= 4'h0;
         slot_q  <= 3'h0;
         ptr_q   <= 8'h00;
         work_q  <= '0;
         image_q <= '0;
      end else if (ce_in) begin
         state_q <= state_d;
         idx_q   <= idx_d;
         slot_q  <= slot_d;
         ptr_q   <= ptr_d;
         work_q  <= work_d;
         image_q <= image_d;
      end
   end

   // ==========================================================================
   // APB read decode. The image is reachable only here, never from a
   // fieldbus port, so the control program must copy what it needs.
   always_comb begin
      hit   = 1'b1;
      rdata = 32'h0000_0000;
      case (paddr_in)
         OFF_CTRL: rdata[CTRL_EN_BIT]   = ctrl_en_q;
         OFF_STAT: rdata[STAT_W-1:0]    = stat_q;
         OFF_MASK: rdata[STAT_W-1:0]    = mask_q;
         OFF_ANA:  rdata[3:0]           = ana_q;
         OFF_KIND: rdata[KIND_REG_W-1:0] = kind_q;
         OFF_FLT:  rdata[NUM_SLOTS-1:0] = flt_slot;
         default: begin
            if (paddr_in[7:6] == OFF_IMG[7:6] && paddr_in[1:0] == 2'h0) begin
               rdata[WORD_W-1:0] = image_q[{paddr_in[5:2], 4'h0} +: WORD_W];
            end else begin
               hit = 1'b0;
            end
         end
      endcase
   end

   // ==========================================================================
   // Register updates. One wait state: ready rises in the second access cycle
   // and a write lands on the edge that samples it.
   always_comb begin
      acc       = psel_in & penable_in;
      wr        = acc & pready_q & pwrite_in;
      pready_d  = acc & ~pready_q;
      prdata_d  = (acc && !pready_q && !pwrite_in && hit) ? rdata : 32'h0000_0000;
      pslverr_d = acc & ~pready_q & ~hit;
      ctrl_en_d = (wr && paddr_in == OFF_CTRL) ? pwdata_in[CTRL_EN_BIT] : ctrl_en_q;
      mask_d    = (wr && paddr_in == OFF_MASK) ? pwdata_in[STAT_W-1:0] : mask_q;
      kind_d    = (wr && paddr_in == OFF_KIND) ? pwdata_in[KIND_REG_W-1:0] : kind_q;
      ana_d     = ana_q;
      if (wr && paddr_in == OFF_ANA) begin
         // Clamp so the analog block never overruns the store.
         ana_d = (pwdata_in[3:0] > 4'(ANA_MAX)) ? 4'(ANA_MAX) : pwdata_in[3:0];
      end
      fprev_d  = fu;
      flt_rise = |(fu & ~fprev_q);
      stat_set = '0;
      stat_set[STAT_DONE_BIT] = done_ev;
      stat_set[STAT_FLT_BIT]  = flt_rise;
      stat_clr = (wr && paddr_in == OFF_STAT) ? pwdata_in[STAT_W-1:0] : '0;
      // A new event outranks a clear written in the same cycle.
      stat_d = (stat_q & ~stat_clr) | stat_set;
      irq_d  = |(stat_d & mask_d);
   end

   always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
         ctrl_en_q <= CTRL_EN_RST;
         stat_q    <= STAT_RST;
         mask_q    <= MASK_RST;
         ana_q     <= ANA_RST;
         kind_q    <= KIND_RST;
         fprev_q   <= '0;
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end else if (ce_in) begin
         ctrl_en_q <= ctrl_en_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
         ana_q     <= ana_d;
         kind_q    <= kind_d;
         fprev_q   <= fprev_d;
         pready_q  <= pready_d;
         prdata_q  <= prdata_d;
         pslverr_q <= pslverr_d;
         irq_q     <= irq_d;
      end
   end

   assign pready_out  = pready_q;
   assign prdata_out  = prdata_q;
   assign pslverr_out = pslverr_q;
   assign irq_out     = irq_q;

   // ==========================================================================
   // Checks on the packing.
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   property p_word_start;
      (state_q == ST_ANALOG && idx_q >= ana_q && ce_in) |=>
         (state_q == ST_DIGITAL && ptr_q[3:0] == 4'h0 && ptr_q[7:4] == $past(ana_q));
   endproperty
   a_word_start: assert property (p_word_start) else $error("digital start off word");

   property p_little_end;
      (state_q == ST_ANALOG && idx_q == 4'h0 && ana_q != 4'h0 && ce_in) |=>
         (work_q[7:0] == $past(analog_word_in[0][7:0]) &&
          work_q[15:8] == $past(analog_word_in[0][15:8]));
   endproperty
   a_little_end: assert property (p_little_end) else $error("analog byte order wrong");

   property p_one_bit;
      (kind_q[0] == KIND_8CH) |-> (fld[0].bits == st_s[0] && fld[0].width == FW_8);
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("channel bit count wrong");

   property p_fault_used;
      (kind_q[0] == KIND_2CH_DIAG) |-> (fu[7:0] == {6'h00, ft_s[0][1:0]});
   endproperty
   a_fault_used: assert property (p_fault_used) else $error("fault flags not used");

   property p_ptr_step;
      (state_q == ST_DIGITAL && ce_in) |=> (ptr_q == 8'($past(ptr_q) + {4'h0, $past(cur_w)}));
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("packing pointer step wrong");

   property p_one_diag;
      (kind_q[0] == KIND_1CH_DIAG) |->
         (fld[0].bits == {6'h00, ft_s[0][0], st_s[0][0]} && fld[0].width == FW_2);
   endproperty
   a_one_diag: assert property (p_one_diag) else $error("single diag layout wrong");

   property p_two_plain;
      (kind_q[0] == KIND_2CH) |-> (fld[0].bits == {6'h00, st_s[0][1:0]} && fld[0].width == FW_2);
   endproperty
   a_two_plain: assert property (p_two_plain) else $error("two channel layout wrong");

   property p_two_diag;
      (kind_q[0] == KIND_2CH_DIAG) |->
         (fld[0].bits == {4'h0, ft_s[0][1:0], st_s[0][1:0]} && fld[0].width == FW_4);
   endproperty
   a_two_diag: assert property (p_two_diag) else $error("two diag layout wrong");

   property p_image_hold;
      !(state_q == ST_PUBLISH && ce_in) |=> $stable(image_q);
   endproperty
   a_image_hold: assert property (p_image_hold) else $error("image changed outside publish");

   property p_clear_start;
      (state_q == ST_IDLE && ctrl_en_q && ce_in) |=> (work_q == '0);
   endproperty
   a_clear_start: assert property (p_clear_start) else $error("work image not cleared");

endmodule : dip_image_packer
`default_nettype wire

// ===== include/dip_pkg.sv
// Shared constants and types for the digital input image packer.
package dip_pkg;

   // ==========================================================================
   // Sizes of the local bus view and of the image store.
   localparam int NUM_SLOTS = 8;                // Digital module slots scanned per pass.
   localparam int CH_MAX    = 8;                // Most channels one module can carry.
   localparam int ANA_MAX   = 8;                // Most analog words ahead of the digital data.
   localparam int WORD_W    = 16;               // Image word width.
   localparam int IMG_WORDS = 16;               // Words in the image store.
   localparam int IMG_BITS  = IMG_WORDS * WORD_W;
   localparam int KIND_W    = 3;                // Width of one slot's module kind code.
   localparam int PIN_W     = 2 * NUM_SLOTS * CH_MAX;

   // ==========================================================================
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFF_CTRL = 8'h00;     // Scan enable.
   localparam logic [7:0] OFF_STAT = 8'h04;     // Sticky events, write one to clear.
   localparam logic [7:0] OFF_MASK = 8'h08;     // Interrupt mask, same layout as status.
   localparam logic [7:0] OFF_ANA  = 8'h0C;     // Number of analog words ahead of the bits.
   localparam logic [7:0] OFF_KIND = 8'h10;     // Module kind code per slot.
   localparam logic [7:0] OFF_FLT  = 8'h14;     // Live fault summary, one bit per slot.
   localparam logic [7:0] OFF_IMG  = 8'h40;     // First word of the published image.

   // ==========================================================================
   // Field positions and reset values.
   localparam int CTRL_EN_BIT   = 0;
   localparam int STAT_DONE_BIT = 0;            // A scan was published.
   localparam int STAT_FLT_BIT  = 1;            // A fault flag rose.
   localparam int STAT_W        = 2;
   localparam int KIND_REG_W    = NUM_SLOTS * KIND_W;
   localparam logic                  CTRL_EN_RST = 1'b0;
   localparam logic [STAT_W-1:0]     STAT_RST    = 2'h0;
   localparam logic [STAT_W-1:0]     MASK_RST    = 2'h0;
   localparam logic [3:0]            ANA_RST     = 4'h0;
   localparam logic [KIND_REG_W-1:0] KIND_RST    = 24'h0;

   // ==========================================================================
   // Module kind codes and the field width each one occupies.
   localparam logic [KIND_W-1:0] KIND_NONE     = 3'h0;
   localparam logic [KIND_W-1:0] KIND_1CH_DIAG = 3'h1;
   localparam logic [KIND_W-1:0] KIND_2CH      = 3'h2;
   localparam logic [KIND_W-1:0] KIND_2CH_DIAG = 3'h3;
   localparam logic [KIND_W-1:0] KIND_4CH      = 3'h4;
   localparam logic [KIND_W-1:0] KIND_8CH      = 3'h5;
   localparam logic [3:0] FW_2 = 4'h2;
   localparam logic [3:0] FW_4 = 4'h4;
   localparam logic [3:0] FW_8 = 4'h8;

   // ==========================================================================
   // Types.
   typedef struct packed {
      logic [CH_MAX-1:0] bits;                  // Field bits, bit 0 first in the image.
      logic [3:0]        width;                 // Number of image bits the field takes.
   } dip_field_s;

   typedef enum {ST_IDLE, ST_ANALOG, ST_DIGITAL, ST_PUBLISH} dip_state_e;

endpackage : dip_pkg

// ===== core/dip_sync.sv
// Two flip-flop synchroniser for the module input pins.
`timescale 1ns/1ps
`default_nettype none

module dip_sync
   import dip_pkg::*;
#(
   parameter int W = 1                          // Number of bits synchronised.
) (
   input  wire logic         clk_in,            // System clock.
   input  wire logic         ce_in,             // Clock enable.
   input  wire logic         rst_in,            // Synchronous reset, active high.
   input  wire logic [W-1:0] d_in,              // Asynchronous pin levels.
   output logic      [W-1:0] q_out              // Levels safe to use on clk_in.
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   // ==========================================================================
   // The first stage feeds only the second stage, never any logic.
   always_comb begin
      meta_d = d_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce_in) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_out = sync_q;

endmodule : dip_sync
`default_nettype wire

// ===== core/dip_field_packer.sv
// Formats one module's channel states and fault flags into its image field.
`timescale 1ns/1ps
`default_nettype none

module dip_field_packer
   import dip_pkg::*;
(
   input  wire logic [KIND_W-1:0] kind_in,      // Module kind in this slot.
   input  wire logic [CH_MAX-1:0] state_in,     // Synchronised channel states.
   input  wire logic [CH_MAX-1:0] fault_in,     // Synchronised fault flags.
   output var  dip_field_s        field_out,    // Field bits and width.
   output logic [CH_MAX-1:0]      fault_used_out // Fault flags this kind reports.
);

   logic channel_one_input_state;
   logic channel_two_input_state;

   assign channel_one_input_state = state_in[0];
   assign channel_two_input_state = state_in[1];

   // ==========================================================================
   // Every bit not named for a kind stays zero, including all bits of an
   // empty slot, so stale pin levels never leak into the image.
   always_comb begin
      field_out      = '0;
      fault_used_out = '0;
      case (kind_in)
         KIND_1CH_DIAG: begin
            field_out.bits[0] = channel_one_input_state;
            field_out.bits[1] = fault_in[0];
            field_out.width   = FW_2;
            fault_used_out[0] = fault_in[0];
         end
         KIND_2CH: begin
            field_out.bits[0] = channel_one_input_state;
            field_out.bits[1] = channel_two_input_state;
            field_out.width   = FW_2;
         end
         KIND_2CH_DIAG: begin
            field_out.bits[0]   = channel_one_input_state;
            field_out.bits[1]   = channel_two_input_state;
            field_out.bits[3:2] = fault_in[1:0];
            field_out.width     = FW_4;
            fault_used_out[1:0] = fault_in[1:0];
         end
         KIND_4CH: begin
            field_out.bits[3:0] = state_in[3:0];
            field_out.width     = FW_4;
         end
         KIND_8CH: begin
            field_out.bits  = state_in;
            field_out.width = FW_8;
         end
         default: begin
            field_out.width = 4'h0;
         end
      endcase
   end

endmodule : dip_field_packer
`default_nettype wire

// ===== testbench/dip_io_model.sv
// Behavioural model of the digital and analog input modules on the local bus.
`timescale 1ns/1ps
`default_nettype none

module dip_io_model
   import dip_pkg::*;
(
   input  wire logic                  clk_in,     // System clock, analog values share it.
   input  wire logic [7:0]            state_in,   // Base channel levels.
   input  wire logic [7:0]            fault_in,   // Base fault levels.
   output var  logic [NUM_SLOTS-1:0][7:0] state_out, // Channel state pins.
   output var  logic [NUM_SLOTS-1:0][7:0] fault_out, // Fault pins.
   output var  logic [ANA_MAX-1:0][15:0]  analog_out // Analog values.
);
   // ==========================================================================
   // Each slot sees the base pattern xored with its index so no two slots match.
   // Analog words carry unequal bytes so a byte swap cannot go unseen.
   always_comb begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
         state_out[s] = state_in ^ 8'(s);
         fault_out[s] = fault_in ^ 8'(s);
      end
      for (int a = 0; a < ANA_MAX; a++) begin
         analog_out[a] = {8'hC0 | 8'(a), 8'h30 | 8'(a)};
      end
   end
endmodule : dip_io_model

`default_nettype wire

// ===== testbench/dip_image_packer_test.sv
// Self-checking testbench of the input image packer, driven over APB.
`timescale 1ns/1ps
`default_nettype none

module dip_image_packer_test;
   import dip_pkg::*;
   logic clk_sys_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out, irq_out;
   logic [7:0]  paddr_in = 8'h00, sp = 8'hA6, fp = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, r;
   logic [NUM_SLOTS-1:0][7:0] chan_state_in, chan_fault_in;
   logic [ANA_MAX-1:0][15:0]  analog_word_in;
   logic [23:0] kinds = 24'h000B51;
   // One kind set per pass; slot 0 takes every kind code except KIND_NONE once.
   logic [4:0][23:0] cfgs = {24'h000665, 24'h0000F4, 24'h00014B, 24'h00011A, 24'h000B51};
   int n_fail = 0, check_count = 0;

   dip_image_packer dip_image_packer_i(.clk_sys_in, .rst_in, .ce_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .prdata_out, .pslverr_out,
      .chan_state_in, .chan_fault_in, .analog_word_in, .irq_out);
   dip_io_model dip_io_model_i(.clk_in(clk_sys_in), .state_in(sp), .fault_in(fp),
      .state_out(chan_state_in), .fault_out(chan_fault_in), .analog_out(analog_word_in));

   // ==========================================================================
   // Clock of 5 ns.
   always #2.5 clk_sys_in = ~clk_sys_in;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      // Ready is looked at mid-cycle, where it has settled; the transfer
      // then completes on the next rising edge, which samples it high.
      do begin
         @(negedge clk_sys_in);
         n++;
      end while (pready_out !== 1'b1 && n < 50);
      if (pready_out !== 1'b1) begin
         n_fail++;
         $display("[ERR] %0t no ready from the slave", $time);
      end
      rd = prdata_out;
      err = pslverr_out;
      @(posedge clk_sys_in);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
      chk(e, experr);
   endtask : rd

   // Polls until the status shows a published pass.
   task automatic wait_done;
      logic e;
      for (int i = 0; i < 100; i++) begin
         apb(1'b0, OFF_STAT, 32'h0, r, e);
         if (r[STAT_DONE_BIT] === 1'b1) break;
      end
      chk(r[STAT_DONE_BIT], 1'b1);
   endtask : wait_done

   // Expected image, built from the module kinds and the model's pin patterns.
   function automatic logic [IMG_BITS-1:0] exp_img(input int ana);
      logic [IMG_BITS-1:0] im;
      logic [7:0]          s, f;
      int                  p;
      im = '0;
      for (int a = 0; a < ana; a++) im[16*a +: 16] = {8'hC0 | 8'(a), 8'h30 | 8'(a)};
      p = 16 * ana;
      for (int k = 0; k < NUM_SLOTS; k++) begin
         s = sp ^ 8'(k);
         f = fp ^ 8'(k);
         case (kinds[3*k +: 3])
            KIND_1CH_DIAG: begin im[p +: 2] = {f[0], s[0]}; p += 2; end
            KIND_2CH:      begin im[p +: 2] = s[1:0]; p += 2; end
            KIND_2CH_DIAG: begin im[p +: 4] = {f[1:0], s[1:0]}; p += 4; end
            KIND_4CH:      begin im[p +: 4] = s[3:0]; p += 4; end
            KIND_8CH:      begin im[p +: 8] = s; p += 8; end
            default: ;
         endcase
      end
      return im;
   endfunction : exp_img

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // ==========================================================================
   // Main sequence: reset values, images for several analog counts, events.
   initial begin
      logic [IMG_BITS-1:0] im;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      rd(OFF_CTRL, 32'h0, 1'b0);
      rd(OFF_STAT, 32'h0, 1'b0);
      rd(OFF_MASK, 32'h0, 1'b0);
      rd(OFF_ANA, 32'h0, 1'b0);
      rd(OFF_KIND, 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      wr(OFF_ANA, 32'hF);
      rd(OFF_ANA, 32'(ANA_MAX), 1'b0);
      wr(OFF_MASK, 32'h1);
      wr(OFF_CTRL, 32'h1);
      // Two clear-and-wait rounds, so the pass that is checked began after
      // the new settings landed and is never a mixed one.
      for (int c = 0; c < 5; c++) begin
         kinds = cfgs[c];
         wr(OFF_KIND, {8'h0, kinds});
         wr(OFF_ANA, 32'(c % 3));
         repeat (2) begin
            wr(OFF_STAT, 32'h3);
            wait_done();
         end
         chk(irq_out, 1'b1);
         im = exp_img(c % 3);
         for (int w = 0; w < 5; w++) rd(OFF_IMG + 8'(4*w), {16'h0, im[16*w +: 16]}, 1'b0);
      end
      wr(OFF_MASK, 32'h2);
      wr(OFF_STAT, 32'h3);
      chk(irq_out, 1'b0);
      fp <= 8'hFF;
      repeat (30) @(posedge clk_sys_in);
      chk(irq_out, 1'b1);
      rd(OFF_FLT, 32'h4, 1'b0);
      wr(OFF_STAT, 32'h2);
      chk(irq_out, 1'b0);
      final_report();
   end

   // Watchdog well above the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_fail++;
      final_report();
   end
endmodule : dip_image_packer_test

`default_nettype wire
